// file: core/chan_corr_pkg.sv
// Constants for the per-channel correction select block
package chan_corr_pkg;
	localparam int CHAN_W    = 8;
	localparam int KIND_W    = 2;
	localparam int DATA_W    = 32;
	localparam int ADDR_W    = 5;
	localparam int MEM_AW    = CHAN_W + KIND_W;
	localparam int NUM_CHAN  = 256;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFS_CTRL      = 5'h00;
	localparam logic [ADDR_W-1:0] OFS_CHAN      = 5'h04;
	localparam logic [ADDR_W-1:0] OFS_STEP      = 5'h08;
	localparam logic [ADDR_W-1:0] OFS_CORR_DATA = 5'h0C;
	localparam logic [ADDR_W-1:0] OFS_CORR_STORE = 5'h10;
	localparam logic [ADDR_W-1:0] OFS_STATUS    = 5'h14;

	// Control fields
	localparam int CTRL_MULTI_BIT  = 0;
	localparam int CTRL_EXTTRG_BIT = 1;
	localparam int CTRL_COMMON_BIT = 2;
	localparam int CTRL_W          = 3;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h0;

	// Step fields
	localparam int STEP_UP_ONE_BIT   = 0;
	localparam int STEP_UP_TEN_BIT   = 1;
	localparam int STEP_DOWN_ONE_BIT = 2;
	localparam int STEP_DOWN_TEN_BIT = 3;
	localparam logic [CHAN_W:0] STEP_ONE = 9'h001;
	localparam logic [CHAN_W:0] STEP_TEN = 9'h00A;
	localparam logic [CHAN_W:0] CHAN_MAX = 9'h0FF;

	// Status fields
	localparam int STAT_BUSY_BIT   = 0;
	localparam int STAT_ANALOG_BIT = 1;
	localparam int STAT_CYCLE_BIT  = 2;
	localparam int STAT_CHAN_LSB   = 8;

	localparam logic [CHAN_W-1:0] CHAN_RESET = 8'h00;
	localparam logic [CHAN_W-1:0] CHAN_LAST  = 8'hFF;
	localparam logic [DATA_W-1:0] DATA_ZERO  = 32'h0000_0000;

	// Kinds of stored correction data
	typedef enum logic [KIND_W-1:0] {
		KIND_OPEN     = 2'h0,
		KIND_SHORT    = 2'h1,
		KIND_LOAD     = 2'h2,
		KIND_LOAD_REF = 2'h3
	} corr_kind_t;
endpackage

// file: core/chan_corr_select.sv
// Per-channel correction select with scanner lines and Avalon-MM registers
// Summary of operation
// - Select one of 256 sets by channel
// - Apply selected channel's stored correction data
// - Scanner port enable tied to multi-correction
// - Lines active low, top line is MSB
// - Trigger with qualify low loads channel
// - Line changes alone never change channel
// - Panel or command channel applies immediately
// - Multi off ignores channel and qualify lines
// - Multi off holds both done outputs low
// - External trigger honoured in external mode
// - Stored data never cleared, survives reset
// - Measured data goes to selected channel
// - Per-channel load reference to selected slot
// - Common load reference to every slot
// - Step controls add ten, one, minus one, ten
// - Trigger on rising edge of input
// - Analog done output low at analog end
// - Cycle done output low at cycle end
`timescale 1ns/1ps
module chan_corr_select (
	input  wire logic                                sys_clk,
	input  wire logic                                nrst,
	input  wire logic                                ce,
	// Avalon-MM slave
	input  wire logic [chan_corr_pkg::ADDR_W-1:0]    avs_address,
	input  wire logic                                avs_read,
	input  wire logic                                avs_write,
	input  wire logic [chan_corr_pkg::DATA_W-1:0]    avs_writedata,
	output logic      [chan_corr_pkg::DATA_W-1:0]    avs_readdata,
	output logic                                     avs_waitrequest,
	// Scanner side
	input  wire logic [chan_corr_pkg::CHAN_W-1:0]    chan_sel_n,
	input  wire logic                                chan_number_qualify_n,
	input  wire logic                                external_trigger_in,
	output logic                                     analog_done_n,
	output logic                                     measure_cycle_done_n,
	// Measurement engine side
	input  wire logic                                internal_trigger,
	input  wire logic                                analog_finished,
	input  wire logic                                cycle_finished,
	input  wire logic [chan_corr_pkg::KIND_W-1:0]    apply_kind,
	output logic      [chan_corr_pkg::DATA_W-1:0]    apply_data,
	output logic                                     multi_corr_on,
	output logic                                     measure_trigger
);

	typedef enum logic {FILL_IDLE, FILL_RUN} fill_state_t;

	logic [chan_corr_pkg::CTRL_W-1:0] ctrl_r, ctrl_nxt;
	logic [chan_corr_pkg::CHAN_W-1:0] chan_r, chan_nxt;
	logic [chan_corr_pkg::DATA_W-1:0] corr_data_r, corr_data_nxt;
	logic [chan_corr_pkg::DATA_W-1:0] rdata_r, rdata_nxt;
	logic                             rd_ack_r, rd_ack_nxt;
	fill_state_t                      fill_r, fill_nxt;
	logic [chan_corr_pkg::CHAN_W-1:0] fill_idx_r, fill_idx_nxt;
	logic                             adone_n_r, adone_n_nxt;
	logic                             cdone_n_r, cdone_n_nxt;
	logic                             mtrig_r, mtrig_nxt;
	logic [chan_corr_pkg::CHAN_W-1:0] sel_s1_r, sel_s2_r;
	logic                             qual_s1_r, qual_s2_r;
	logic                             trg_s1_r, trg_s2_r, trg_s3_r;

	logic                             multi_on, ext_mode, common_ref;
	logic                             wr_ok, rd_take, trig_fire, ext_edge;
	logic [chan_corr_pkg::CHAN_W:0]   step_sum;
	logic                             step_down;
	logic [chan_corr_pkg::KIND_W-1:0] store_kind;
	logic                             mem_we;
	logic [chan_corr_pkg::MEM_AW-1:0] mem_waddr, mem_raddr;
	logic [chan_corr_pkg::DATA_W-1:0] mem_wdata;

	assign multi_on   = ctrl_r[chan_corr_pkg::CTRL_MULTI_BIT];
	assign ext_mode   = ctrl_r[chan_corr_pkg::CTRL_EXTTRG_BIT];
	assign common_ref = ctrl_r[chan_corr_pkg::CTRL_COMMON_BIT];
	assign store_kind = avs_writedata[chan_corr_pkg::KIND_W-1:0];

	// Bus handshake; a common fill stalls the bus until every slot is written
	assign avs_waitrequest = (avs_read | avs_write)
		& (~ce | (fill_r == FILL_RUN) | (avs_read & ~rd_ack_r));
	assign wr_ok   = avs_write & ~avs_waitrequest;
	assign rd_take = avs_read & ~rd_ack_r & ce & (fill_r == FILL_IDLE);
	assign avs_readdata = rdata_r;

	// Scanner lines and qualify through two flops each, trigger through three
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			sel_s1_r  <= chan_corr_pkg::CHAN_RESET;
			sel_s2_r  <= chan_corr_pkg::CHAN_RESET;
			qual_s1_r <= 1'b1;
			qual_s2_r <= 1'b1;
			trg_s1_r  <= 1'b0;
			trg_s2_r  <= 1'b0;
			trg_s3_r  <= 1'b0;
		end else if (ce) begin
			sel_s1_r  <= chan_sel_n;
			sel_s2_r  <= sel_s1_r;
			qual_s1_r <= chan_number_qualify_n;
			qual_s2_r <= qual_s1_r;
			trg_s1_r  <= external_trigger_in;
			trg_s2_r  <= trg_s1_r;
			trg_s3_r  <= trg_s2_r;
		end
	end

	// Lines share the trigger's latency, so the number is sampled coherently
	assign ext_edge  = trg_s2_r & ~trg_s3_r;
	assign trig_fire = ext_mode ? ext_edge : internal_trigger;

	always_comb begin
		// Only the highest-priority step bit counts; presses never add up
		step_sum  = {1'b0, chan_r};
		step_down = 1'b0;
		if (avs_writedata[chan_corr_pkg::STEP_UP_TEN_BIT]) begin
			step_sum = step_sum + chan_corr_pkg::STEP_TEN;
		end else if (avs_writedata[chan_corr_pkg::STEP_UP_ONE_BIT]) begin
			step_sum = step_sum + chan_corr_pkg::STEP_ONE;
		end else if (avs_writedata[chan_corr_pkg::STEP_DOWN_ONE_BIT]) begin
			step_sum  = step_sum - chan_corr_pkg::STEP_ONE;
			step_down = 1'b1;
		end else if (avs_writedata[chan_corr_pkg::STEP_DOWN_TEN_BIT]) begin
			step_sum  = step_sum - chan_corr_pkg::STEP_TEN;
			step_down = 1'b1;
		end
	end

	// Control, channel and data registers
	always_comb begin
		ctrl_nxt      = ctrl_r;
		chan_nxt      = chan_r;
		corr_data_nxt = corr_data_r;
		if (wr_ok && avs_address == chan_corr_pkg::OFS_CTRL) begin
			ctrl_nxt = avs_writedata[chan_corr_pkg::CTRL_W-1:0];
		end
		if (wr_ok && avs_address == chan_corr_pkg::OFS_CORR_DATA) begin
			corr_data_nxt = avs_writedata;
		end
		// Scanner update first so a same-cycle command still wins
		if (trig_fire && multi_on && !qual_s2_r) begin
			chan_nxt = ~sel_s2_r;
		end
		if (wr_ok && avs_address == chan_corr_pkg::OFS_CHAN) begin
			chan_nxt = avs_writedata[chan_corr_pkg::CHAN_W-1:0];
		end
		if (wr_ok && avs_address == chan_corr_pkg::OFS_STEP) begin
			// Saturate at the ends rather than wrap to a far channel
			if (step_sum[chan_corr_pkg::CHAN_W]) begin
				// The chosen step's direction, not the raw bits, picks the end
				chan_nxt = step_down ? chan_corr_pkg::CHAN_RESET
					: chan_corr_pkg::CHAN_LAST;
			end else begin
				chan_nxt = step_sum[chan_corr_pkg::CHAN_W-1:0];
			end
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_r      <= chan_corr_pkg::CTRL_RESET;
			chan_r      <= chan_corr_pkg::CHAN_RESET;
			corr_data_r <= chan_corr_pkg::DATA_ZERO;
		end else if (ce) begin
			ctrl_r      <= ctrl_nxt;
			chan_r      <= chan_nxt;
			corr_data_r <= corr_data_nxt;
		end
	end

	// Store path and common load-reference fill
	always_comb begin
		fill_nxt     = fill_r;
		fill_idx_nxt = fill_idx_r;
		mem_we       = 1'b0;
		mem_waddr    = {chan_r, store_kind};
		mem_wdata    = corr_data_r;
		unique case (fill_r)
			FILL_IDLE: begin
				if (wr_ok && avs_address == chan_corr_pkg::OFS_CORR_STORE) begin
					if (store_kind == chan_corr_pkg::KIND_LOAD_REF
						&& common_ref) begin
						fill_nxt     = FILL_RUN;
						fill_idx_nxt = chan_corr_pkg::CHAN_RESET;
					end else begin
						mem_we = 1'b1;
					end
				end
			end
			FILL_RUN: begin
				// One slot a cycle; the bus stays stalled until the last
				mem_we    = 1'b1;
				mem_waddr = {fill_idx_r, chan_corr_pkg::KIND_LOAD_REF};
				fill_idx_nxt = fill_idx_r + 8'h01;
				if (fill_idx_r == chan_corr_pkg::CHAN_LAST) begin
					fill_nxt = FILL_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			fill_r     <= FILL_IDLE;
			fill_idx_r <= chan_corr_pkg::CHAN_RESET;
		end else if (ce) begin
			fill_r     <= fill_nxt;
			fill_idx_r <= fill_idx_nxt;
		end
	end

	// Register readback
	always_comb begin
		rd_ack_nxt = rd_take;
		rdata_nxt  = rdata_r;
		if (rd_take) begin
			rdata_nxt = chan_corr_pkg::DATA_ZERO;
			unique case (avs_address)
				chan_corr_pkg::OFS_CTRL:
					rdata_nxt[chan_corr_pkg::CTRL_W-1:0] = ctrl_r;
				chan_corr_pkg::OFS_CHAN:
					rdata_nxt[chan_corr_pkg::CHAN_W-1:0] = chan_r;
				chan_corr_pkg::OFS_CORR_DATA:
					rdata_nxt = corr_data_r;
				chan_corr_pkg::OFS_STATUS: begin
					rdata_nxt[chan_corr_pkg::STAT_BUSY_BIT]   = (fill_r == FILL_RUN);
					rdata_nxt[chan_corr_pkg::STAT_ANALOG_BIT] = adone_n_r;
					rdata_nxt[chan_corr_pkg::STAT_CYCLE_BIT]  = cdone_n_r;
					rdata_nxt[chan_corr_pkg::STAT_CHAN_LSB +: chan_corr_pkg::CHAN_W] = chan_r;
				end
				default:
					rdata_nxt = chan_corr_pkg::DATA_ZERO;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rd_ack_r <= 1'b0;
			rdata_r  <= chan_corr_pkg::DATA_ZERO;
		end else if (ce) begin
			rd_ack_r <= rd_ack_nxt;
			rdata_r  <= rdata_nxt;
		end
	end

	// Done outputs and the engine's trigger pulse
	always_comb begin
		adone_n_nxt = adone_n_r;
		cdone_n_nxt = cdone_n_r;
		mtrig_nxt   = trig_fire;
		// Held low while off, so a waiting scanner is never stalled
		if (!multi_on) begin
			adone_n_nxt = 1'b0;
			cdone_n_nxt = 1'b0;
		end else begin
			// A finish in the trigger's cycle wins, so that done output goes low
			if (trig_fire) begin
				adone_n_nxt = 1'b1;
				cdone_n_nxt = 1'b1;
			end
			if (analog_finished) begin
				adone_n_nxt = 1'b0;
			end
			if (cycle_finished) begin
				cdone_n_nxt = 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			adone_n_r <= 1'b0;
			cdone_n_r <= 1'b0;
			mtrig_r   <= 1'b0;
		end else if (ce) begin
			adone_n_r <= adone_n_nxt;
			cdone_n_r <= cdone_n_nxt;
			mtrig_r   <= mtrig_nxt;
		end
	end

	assign analog_done_n        = adone_n_r;
	assign measure_cycle_done_n = cdone_n_r;
	assign measure_trigger      = mtrig_r;
	assign multi_corr_on        = multi_on;
	assign mem_raddr            = {chan_r, apply_kind};

	corr_store_mem u_store (
		.sys_clk (sys_clk),
		.ce      (ce),
		.wr_en   (mem_we),
		.wr_addr (mem_waddr),
		.wr_data (mem_wdata),
		.rd_addr (mem_raddr),
		.rd_data (apply_data)
	);
endmodule

// file: core/corr_store_mem.sv
// Correction data store, no reset on contents
`timescale 1ns/1ps
module corr_store_mem (
	input  wire logic                                  sys_clk,
	input  wire logic                                  ce,
	input  wire logic                                  wr_en,
	input  wire logic [chan_corr_pkg::MEM_AW-1:0]      wr_addr,
	input  wire logic [chan_corr_pkg::DATA_W-1:0]      wr_data,
	input  wire logic [chan_corr_pkg::MEM_AW-1:0]      rd_addr,
	output logic      [chan_corr_pkg::DATA_W-1:0]      rd_data
);
	logic [chan_corr_pkg::DATA_W-1:0] mem [0:(1 << chan_corr_pkg::MEM_AW)-1];

	// No reset and no clear path: contents must outlive any reset
	always_ff @(posedge sys_clk) begin
		if (ce) begin
			if (wr_en) begin
				mem[wr_addr] <= wr_data;
			end
			rd_data <= mem[rd_addr];
		end
	end
endmodule

// file: verif/chan_corr_select_asserts.sv
// Port checker for the correction select block
`timescale 1ns/1ps
module chan_corr_select_asserts (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic avs_read,
	input wire logic avs_waitrequest,
	input wire logic external_trigger_in,
	input wire logic internal_trigger,
	input wire logic analog_finished,
	input wire logic cycle_finished,
	input wire logic analog_done_n,
	input wire logic measure_cycle_done_n,
	input wire logic multi_corr_on,
	input wire logic measure_trigger
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	sequence s_quiet;
		!measure_trigger ##1 !measure_trigger;
	endsequence
	sequence s_rd_wait;
		avs_waitrequest ##[1:300] !avs_waitrequest;
	endsequence
	property p_off_low;
		!multi_corr_on && !$past(multi_corr_on) |-> !analog_done_n && !measure_cycle_done_n;
	endproperty
	property p_ana_fin;
		analog_finished |=> !analog_done_n;
	endproperty
	property p_cyc_fin;
		cycle_finished |=> !measure_cycle_done_n;
	endproperty
	property p_trig_done;
		measure_trigger && $past(multi_corr_on) && !$past(analog_finished)
			&& !$past(cycle_finished) |-> analog_done_n && measure_cycle_done_n;
	endproperty
	property p_mt_pulse;
		measure_trigger |=> !measure_trigger;
	endproperty
	property p_sync;
		$rose(external_trigger_in) |=> s_quiet;
	endproperty
	property p_mt_cause;
		measure_trigger |-> $past(internal_trigger)
			|| ($past(external_trigger_in, 3) && !$past(external_trigger_in, 4));
	endproperty
	property p_rd;
		$rose(avs_read) |-> s_rd_wait;
	endproperty
	a_off_low: assert property (p_off_low) else $error("done outputs high while multi off");
	a_ana_fin: assert property (p_ana_fin) else $error("analog done not low");
	a_cyc_fin: assert property (p_cyc_fin) else $error("cycle done not low");
	a_trig_done: assert property (p_trig_done) else $error("done not raised");
	a_mt_pulse: assert property (p_mt_pulse) else $error("trigger pulse too long");
	a_sync: assert property (p_sync) else $error("trigger too early");
	a_mt_cause: assert property (p_mt_cause) else $error("trigger without cause");
	a_rd: assert property (p_rd) else $error("read stall wrong");
endmodule

bind chan_corr_select chan_corr_select_asserts u_chan_corr_select_asserts (.sys_clk, .nrst,
	.avs_read, .avs_waitrequest, .external_trigger_in, .internal_trigger, .analog_finished,
	.cycle_finished, .analog_done_n, .measure_cycle_done_n, .multi_corr_on, .measure_trigger);

// file: verif/chan_corr_select_bench.sv
// Testbench for the correction select block
`timescale 1ns/1ps
module chan_corr_select_bench;
	logic        sys_clk, nrst, ce, avs_read, avs_write, avs_waitrequest, go, qlow, fire, busy;
	logic        internal_trigger, analog_finished, cycle_finished, chan_number_qualify_n;
	logic        external_trigger_in, analog_done_n, measure_cycle_done_n;
	logic        multi_corr_on, measure_trigger;
	logic [1:0]  apply_kind;
	logic [4:0]  avs_address;
	logic [7:0]  chan_sel_n, num, v;
	logic [31:0] avs_writedata, avs_readdata, apply_data, d, c;
	logic [31:0] q[$];
	int          fails, cmp_count, mt_n, seed, i;
	logic [7:0]  ss[7] = '{8'h05, 8'h05, 8'h05, 8'h0F, 8'h03, 8'hFA, 8'hFA};
	logic [7:0]  sb[7] = '{8'h02, 8'h01, 8'h04, 8'h08, 8'h08, 8'h02, 8'h06};
	logic [7:0]  se[7] = '{8'h0F, 8'h06, 8'h04, 8'h05, 8'h00, 8'hFF, 8'hFF};
	chan_corr_select u_chan_corr_select (.sys_clk, .nrst, .ce, .avs_address, .avs_read,
		.avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .chan_sel_n,
		.chan_number_qualify_n, .external_trigger_in, .analog_done_n, .measure_cycle_done_n,
		.internal_trigger, .analog_finished, .cycle_finished, .apply_kind, .apply_data,
		.multi_corr_on, .measure_trigger);
	scanner_model u_scanner_model (.sys_clk, .go, .num, .qlow, .fire, .chan_sel_n,
		.chan_number_qualify_n, .external_trigger_in, .busy);
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			fails++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask
	// Request held until the edge that sees waitrequest low
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] wd);
		int n;
		avs_address <= a;
		avs_writedata <= wd;
		avs_write <= w;
		avs_read <= !w;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 400);
		if (n >= 400) begin
			fails++;
			report_and_stop();
		end
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic rd(input logic [4:0] a, input logic [31:0] e);
		q.push_back(e);
		bus(1'b0, a, 32'h0000_0000);
	endtask
	function automatic logic [31:0] st(input logic [7:0] ch, input logic an, input logic cy);
		return {16'h0000, ch, 5'h00, cy, an, 1'b0};
	endfunction
	task automatic frame(input logic [7:0] n, input logic ql, input logic fi);
		int k;
		num <= n;
		qlow <= ql;
		fire <= fi;
		go <= 1'b1;
		@(posedge sys_clk);
		go <= 1'b0;
		k = 0;
		do begin
			@(posedge sys_clk);
			k++;
		end while (busy !== 1'b0 && k < 50);
		if (k >= 50) begin
			fails++;
			report_and_stop();
		end
	endtask
	task automatic look(input logic [1:0] k, input logic [31:0] e);
		apply_kind <= k;
		repeat (3) @(posedge sys_clk);
		chk("apply_data", apply_data, e);
	endtask
	always @(posedge sys_clk) begin
		if (avs_read && avs_waitrequest === 1'b0)
			chk("readdata", avs_readdata, q.pop_front());
		if (measure_trigger === 1'b1)
			mt_n++;
	end
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	initial begin
		{nrst, avs_read, avs_write, go, qlow, fire, internal_trigger} = 7'h00;
		{analog_finished, cycle_finished, apply_kind, avs_address, num} = 17'h00000;
		{avs_writedata, fails, cmp_count, mt_n} = 0;
		ce = 1'b1;
		seed = 72404;
		repeat (6) @(posedge sys_clk);
		nrst <= 1'b1;
		@(posedge sys_clk);
		rd(5'h00, 32'h0000_0000);
		rd(5'h18, 32'h0000_0000);
		v = 8'($random(seed));
		bus(1'b1, 5'h04, 32'(v));
		rd(5'h14, st(v, 1'b0, 1'b0));
		for (i = 0; i < 7; i++) begin
			bus(1'b1, 5'h04, 32'(ss[i]));
			bus(1'b1, 5'h08, 32'(sb[i]));
			rd(5'h14, st(se[i], 1'b0, 1'b0));
		end
		bus(1'b1, 5'h00, 32'h0000_0002);
		frame(8'($random(seed)), 1'b1, 1'b1);
		rd(5'h14, st(8'hFF, 1'b0, 1'b0));
		chk("trigger count", mt_n, 1);
		bus(1'b1, 5'h00, 32'h0000_0003);
		chk("multi", 32'(multi_corr_on), 32'h0000_0001);
		v = 8'($random(seed));
		frame(v, 1'b1, 1'b1);
		rd(5'h14, st(v, 1'b1, 1'b1));
		analog_finished <= 1'b1;
		@(posedge sys_clk);
		analog_finished <= 1'b0;
		rd(5'h14, st(v, 1'b0, 1'b1));
		cycle_finished <= 1'b1;
		@(posedge sys_clk);
		cycle_finished <= 1'b0;
		rd(5'h14, st(v, 1'b0, 1'b0));
		frame(~v, 1'b1, 1'b0);
		rd(5'h14, st(v, 1'b0, 1'b0));
		frame(~v, 1'b0, 1'b1);
		rd(5'h14, st(v, 1'b1, 1'b1));
		bus(1'b1, 5'h00, 32'h0000_0001);
		internal_trigger <= 1'b1;
		@(posedge sys_clk);
		internal_trigger <= 1'b0;
		repeat (3) @(posedge sys_clk);
		chk("trigger count", mt_n, 4);
		ce <= 1'b0;
		internal_trigger <= 1'b1;
		@(posedge sys_clk);
		internal_trigger <= 1'b0;
		repeat (2) @(posedge sys_clk);
		ce <= 1'b1;
		repeat (3) @(posedge sys_clk);
		chk("frozen trigger count", mt_n, 4);
		// Common fill stalls the bus for the whole sweep
		c = $random(seed);
		bus(1'b1, 5'h00, 32'h0000_0005);
		bus(1'b1, 5'h0C, c);
		bus(1'b1, 5'h10, 32'h0000_0003);
		bus(1'b1, 5'h04, 32'h0000_00C8);
		look(2'h3, c);
		bus(1'b1, 5'h00, 32'h0000_0001);
		bus(1'b1, 5'h04, 32'h0000_0007);
		for (i = 0; i < 4; i++) begin
			d = $random(seed);
			bus(1'b1, 5'h0C, d);
			bus(1'b1, 5'h10, 32'(i));
			look(2'(i), d);
		end
		bus(1'b1, 5'h04, 32'h0000_0008);
		look(2'h3, c);
		nrst <= 1'b0;
		repeat (2) @(posedge sys_clk);
		nrst <= 1'b1;
		@(posedge sys_clk);
		bus(1'b1, 5'h04, 32'h0000_0007);
		look(2'h3, d);
		report_and_stop();
	end
endmodule

// file: verif/scanner_model.sv
// Scanner fixture model driving the channel lines and trigger
`timescale 1ns/1ps
module scanner_model (
	input  wire logic       sys_clk,
	input  wire logic       go,
	input  wire logic [7:0] num,
	input  wire logic       qlow,
	input  wire logic       fire,
	output logic      [7:0] chan_sel_n,
	output logic            chan_number_qualify_n,
	output logic            external_trigger_in,
	output logic            busy
);
	initial begin
		chan_sel_n = 8'hFF;
		chan_number_qualify_n = 1'b1;
		external_trigger_in = 1'b0;
		busy = 1'b0;
		forever begin
			@(posedge sys_clk);
			if (go) begin
				busy <= 1'b1;
				chan_number_qualify_n <= 1'b1;
				@(posedge sys_clk);
				chan_sel_n <= ~num;
				repeat (2) @(posedge sys_clk);
				chan_number_qualify_n <= !qlow;
				repeat (2) @(posedge sys_clk);
				external_trigger_in <= fire;
				repeat (3) @(posedge sys_clk);
				external_trigger_in <= 1'b0;
				repeat (3) @(posedge sys_clk);
				// Released lines show the inverse, not the old number
				chan_sel_n <= num;
				chan_number_qualify_n <= 1'b1;
				busy <= 1'b0;
			end
		end
	end
endmodule
